// [rtl/alarm_event_pkg.sv]
// Constants and types shared by the alarm delay, contact input and colour logic.
package alarm_event_pkg;
  localparam int NUM_ALARMS = 3;

  // Register byte offsets.
  localparam logic [7:0] OFS_CONTACT  = 8'h00;
  localparam logic [7:0] OFS_COLOUR   = 8'h04;
  localparam logic [7:0] OFS_COL_HIGH = 8'h08;
  localparam logic [7:0] OFS_COL_LOW  = 8'h0C;
  localparam logic [7:0] OFS_PV       = 8'h10;
  localparam logic [7:0] OFS_SP       = 8'h14;
  localparam logic [7:0] OFS_LATCH    = 8'h18;
  localparam logic [7:0] OFS_KEY      = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_ON_DLY   = 8'h30;
  localparam logic [7:0] OFS_OFF_DLY  = 8'h40;

  // Field positions.
  localparam int DLY_MIN_LSB    = 8;
  localparam int DLY_SEC_LSB    = 0;
  localparam int ST_BACKLIGHT   = 4;
  localparam int ST_RED         = 5;
  localparam int ST_MSG         = 6;
  localparam int ST_MSG_SEL_LSB = 8;
  localparam int ST_CONTACT     = 12;

  // Contact function codes.
  localparam logic [2:0] FN_NONE      = 3'h0;
  localparam logic [2:0] FN_LATCH     = 3'h1;
  localparam logic [2:0] FN_BACKLIGHT = 3'h2;
  localparam logic [2:0] FN_COLOUR    = 3'h3;
  localparam logic [2:0] FN_MSG1      = 3'h4;

  // Colour mode codes.
  localparam logic [3:0] CM_WHITE   = 4'h0;
  localparam logic [3:0] CM_RED     = 4'h1;
  localparam logic [3:0] CM_AL1     = 4'h2;
  localparam logic [3:0] CM_AL1_INV = 4'h3;
  localparam logic [3:0] CM_AL12    = 4'h4;
  localparam logic [3:0] CM_AL12_INV = 4'h5;
  localparam logic [3:0] CM_PV      = 4'h6;
  localparam logic [3:0] CM_PV_INV  = 4'h7;
  localparam logic [3:0] CM_DEV     = 4'h8;
  localparam logic [3:0] CM_DEV_INV = 4'h9;
  localparam logic [3:0] CM_CONTACT = 4'hA;
  localparam logic [3:0] CM_EXCEED  = 4'hB;
  localparam logic [3:0] CM_OUTLAMP = 4'hC;

  // Reset values.
  localparam logic [2:0] RST_CONTACT_FN = FN_NONE;
  localparam logic [3:0] RST_COLOUR     = CM_WHITE;
  localparam logic       RST_BACKLIGHT  = 1'b1;

  // Delay setting limits.
  localparam logic [6:0] DLY_MAX_MIN = 7'd99;
  localparam logic [5:0] DLY_MAX_SEC = 6'd59;

  // Time base.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int TICK_PERIOD_MS  = 10;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICKS_PER_SEC   = 1000 / TICK_PERIOD_MS;
  localparam int SEC_PER_MIN     = 60;
  localparam int CONTACT_HOLD_MS = 250;
  localparam int CONTACT_HOLD_TICKS =
    (CONTACT_HOLD_MS + TICK_PERIOD_MS - 1) / TICK_PERIOD_MS + 1;

  typedef enum logic [1:0] {ST_IDLE, ST_ON_WAIT, ST_ON, ST_OFF_WAIT} alarm_state_e;
endpackage

// [rtl/alarm_event_logic.sv]
// Alarm delay timers, contact input actions and display colour selection.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module alarm_event_logic
  import alarm_event_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        contactPin,
  input  wire logic [2:0]  alarmCond,
  input  wire logic        exceededLamp,
  input  wire logic        outLamp,
  output logic [2:0]       alarmOut,
  output logic             latchRelease,
  output logic             backlightOn,
  output logic             displayRed,
  output logic             messageActive,
  output logic [1:0]       messageSel
);
  logic               awHeld_r;
  logic [7:0]         awAddr_r;
  logic               wHeld_r;
  logic [31:0]        wData_r;
  logic [3:0]         wStrb_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic               wrDo;
  logic [31:0]        wrVal;
  logic [32:0]        wrReg;
  logic [32:0]        rdReg;
  logic [2:0]         contactFunc_r;
  logic [3:0]         colourMode_r;
  logic signed [15:0] colHigh_r;
  logic signed [15:0] colLow_r;
  logic signed [15:0] pv_r;
  logic signed [15:0] sp_r;
  logic [2:0]         latchEn_r;
  logic [12:0]        onDly_r [NUM_ALARMS];
  logic [12:0]        offDly_r [NUM_ALARMS];
  logic               keyPress_r;
  logic [19:0]        tickCnt_r;
  logic               tick_r;
  logic               sync1_r;
  logic               sync2_r;
  logic               contactLvl_r;
  logic [4:0]         holdCnt_r;
  logic               contactRise_r;
  logic               contactFall_r;
  logic [2:0]         dlyOn;
  logic [2:0]         latched_r;
  logic [2:0]         alarmOut_r;
  logic               latchRelease_r;
  logic               backlightOn_r;
  logic               messageActive_r;
  logic [1:0]         messageSel_r;
  logic               displayRed_r;
  logic               redNxt;
  logic               pvOut;
  logic               devOut;
  logic signed [16:0] dev;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  function automatic logic [12:0] clampDly(input logic [31:0] v);
    logic [6:0] m;
    logic [5:0] s;
    m = v[DLY_MIN_LSB +: 7];
    s = v[DLY_SEC_LSB +: 6];
    if (m > DLY_MAX_MIN)
      m = DLY_MAX_MIN;
    if (s > DLY_MAX_SEC)
      s = DLY_MAX_SEC;
    return {m, s};
  endfunction

  function automatic logic [31:0] dlyWord(input logic [12:0] d);
    logic [31:0] v;
    v = 32'h0;
    v[DLY_MIN_LSB +: 7] = d[12:6];
    v[DLY_SEC_LSB +: 6] = d[5:0];
    return v;
  endfunction

  // Returns the hit flag above the register contents of one address.
  function automatic logic [32:0] regValue(input logic [7:0] a);
    logic [31:0] st;
    logic [32:0] r;
    st = 32'h0;
    st[2:0] = alarmOut_r;
    st[ST_BACKLIGHT] = backlightOn_r;
    st[ST_RED] = displayRed_r;
    st[ST_MSG] = messageActive_r;
    st[ST_MSG_SEL_LSB +: 2] = messageSel_r;
    st[ST_CONTACT] = contactLvl_r;
    r = {1'b0, 32'h0};
    case (a)
      OFS_CONTACT:  r = {1'b1, 29'h0, contactFunc_r};
      OFS_COLOUR:   r = {1'b1, 28'h0, colourMode_r};
      OFS_COL_HIGH: r = {1'b1, 16'h0, colHigh_r};
      OFS_COL_LOW:  r = {1'b1, 16'h0, colLow_r};
      OFS_PV:       r = {1'b1, 16'h0, pv_r};
      OFS_SP:       r = {1'b1, 16'h0, sp_r};
      OFS_LATCH:    r = {1'b1, 29'h0, latchEn_r};
      OFS_KEY:      r = {1'b1, 32'h0};
      OFS_STATUS:   r = {1'b1, st};
      default:
        for (int i = 0; i < NUM_ALARMS; i++)
        begin
          if (a == OFS_ON_DLY + 8'(4 * i))
            r = {1'b1, dlyWord(onDly_r[i])};
          if (a == OFS_OFF_DLY + 8'(4 * i))
            r = {1'b1, dlyWord(offDly_r[i])};
        end
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        m[8*b +: 8] = n[8*b +: 8];
    return m;
  endfunction

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign wrDo  = awHeld_r && wHeld_r && !bvalid_r;
  assign wrVal = merge(wrReg[31:0], wData_r, wStrb_r);

  // Register contents at the pending write address and at the offered read address.
  always_comb
  begin
    wrReg = regValue(awAddr_r);
    rdReg = regValue({s_axi_araddr[7:2], 2'h0});
  end

  // Write channel: address and data are held until both have arrived.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      awHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wHeld_r  <= 1'b0;
      wData_r  <= 32'h0;
      wStrb_r  <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !awHeld_r)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && !wHeld_r)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrDo)
      begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= wrReg[32] ? 2'h0 : 2'h2;
      end
      else if (bvalid_r && s_axi_bready)
        bvalid_r <= 1'b0;
    end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= 2'h0;
    end
    else if (s_axi_arvalid && !rvalid_r)
    begin
      rvalid_r <= 1'b1;
      rdata_r  <= rdReg[31:0];
      rresp_r  <= rdReg[32] ? 2'h0 : 2'h2;
    end
    else if (rvalid_r && s_axi_rready)
      rvalid_r <= 1'b0;

  // Configuration registers.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      contactFunc_r <= RST_CONTACT_FN;
      colourMode_r  <= RST_COLOUR;
      colHigh_r     <= 16'sh0;
      colLow_r      <= 16'sh0;
      pv_r          <= 16'sh0;
      sp_r          <= 16'sh0;
      latchEn_r     <= 3'h0;
      keyPress_r    <= 1'b0;
      for (int i = 0; i < NUM_ALARMS; i++)
      begin
        onDly_r[i]  <= 13'h0;
        offDly_r[i] <= 13'h0;
      end
    end
    else
    begin
      keyPress_r <= wrDo && (awAddr_r == OFS_KEY) && wrVal[0];
      if (wrDo)
      begin
        case (awAddr_r)
          OFS_CONTACT:  contactFunc_r <= wrVal[2:0];
          OFS_COLOUR:   colourMode_r <= wrVal[3:0];
          OFS_COL_HIGH: colHigh_r <= wrVal[15:0];
          OFS_COL_LOW:  colLow_r <= wrVal[15:0];
          OFS_PV:       pv_r <= wrVal[15:0];
          OFS_SP:       sp_r <= wrVal[15:0];
          OFS_LATCH:    latchEn_r <= wrVal[2:0];
          default:      ;
        endcase
        for (int i = 0; i < NUM_ALARMS; i++)
        begin
          if (awAddr_r == OFS_ON_DLY + 8'(4 * i))
            onDly_r[i] <= clampDly(wrVal);
          if (awAddr_r == OFS_OFF_DLY + 8'(4 * i))
            offDly_r[i] <= clampDly(wrVal);
        end
      end
    end

  // Shared slow time base.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      tickCnt_r <= 20'h0;
      tick_r    <= 1'b0;
    end
    else
    begin
      tick_r <= (tickCnt_r == 20'(TICK_CYCLES - 1));
      if (tickCnt_r == 20'(TICK_CYCLES - 1))
        tickCnt_r <= 20'h0;
      else
        tickCnt_r <= tickCnt_r + 20'h1;
    end

  // Contact synchroniser and hold qualification.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      sync1_r       <= 1'b0;
      sync2_r       <= 1'b0;
      contactLvl_r  <= 1'b0;
      holdCnt_r     <= 5'h0;
      contactRise_r <= 1'b0;
      contactFall_r <= 1'b0;
    end
    else
    begin
      sync1_r <= contactPin;
      sync2_r <= sync1_r;
      contactRise_r <= 1'b0;
      contactFall_r <= 1'b0;
      if (sync2_r == contactLvl_r)
        holdCnt_r <= 5'h0;
      else if (tick_r)
      begin
        if (holdCnt_r == 5'(CONTACT_HOLD_TICKS - 1))
        begin
          holdCnt_r     <= 5'h0;
          contactLvl_r  <= sync2_r;
          contactRise_r <= sync2_r;
          contactFall_r <= !sync2_r;
        end
        else
          holdCnt_r <= holdCnt_r + 5'h1;
      end
    end

  sequence sRiseSeen;
    contactRise_r;
  endsequence
  sequence sMsgShown;
    messageActive_r && (messageSel_r == $past(2'(contactFunc_r - FN_MSG1)));
  endsequence

  AST_HOLD_QUALIFIED: assert property (contactRise_r |-> $past(sync2_r) && $past(tick_r))
    else $error("Contact rise without a qualified hold.");
  AST_FALL_QUALIFIED: assert property (contactFall_r |-> !$past(sync2_r) && $past(tick_r))
    else $error("Contact fall without a qualified hold.");
  AST_ONE_PULSE: assert property (sRiseSeen |=> !contactRise_r [*2])
    else $error("Contact rise pulse repeated.");

  // Per-alarm on-delay and off-delay timers.
  for (genvar g = 0; g < NUM_ALARMS; g++)
  begin : gAlarm
    alarm_state_e state_r;
    logic [19:0]  cnt_r;
    logic [19:0]  onT;
    logic [19:0]  offT;
    assign onT  = (20'(onDly_r[g][12:6]) * 20'(SEC_PER_MIN) + 20'(onDly_r[g][5:0]))
                  * 20'(TICKS_PER_SEC);
    assign offT = (20'(offDly_r[g][12:6]) * 20'(SEC_PER_MIN) + 20'(offDly_r[g][5:0]))
                  * 20'(TICKS_PER_SEC);
    assign dlyOn[g] = (state_r == ST_ON) || (state_r == ST_OFF_WAIT);

    always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
        state_r <= ST_IDLE;
        cnt_r   <= 20'h0;
      end
      else
        case (state_r)
          ST_IDLE:
          begin
            cnt_r <= 20'h0;
            if (alarmCond[g])
              state_r <= (onT == 20'h0) ? ST_ON : ST_ON_WAIT;
          end
          ST_ON_WAIT:
            if (!alarmCond[g])
            begin
              state_r <= ST_IDLE;
              cnt_r   <= 20'h0;
            end
            else if (tick_r)
            begin
              if (cnt_r >= onT)
                state_r <= ST_ON;
              else
                cnt_r <= cnt_r + 20'h1;
            end
          ST_ON:
          begin
            cnt_r <= 20'h0;
            if (!alarmCond[g])
              state_r <= (offT == 20'h0) ? ST_IDLE : ST_OFF_WAIT;
          end
          ST_OFF_WAIT:
            if (alarmCond[g])
            begin
              state_r <= ST_ON;
              cnt_r   <= 20'h0;
            end
            else if (tick_r)
            begin
              if (cnt_r >= offT)
                state_r <= ST_IDLE;
              else
                cnt_r <= cnt_r + 20'h1;
            end
          default: state_r <= ST_IDLE;
        endcase

    AST_ON_LATE: assert property ($rose(dlyOn[g]) && $past(onT) != 20'h0 |->
                                  $past(tick_r) && $past(cnt_r) >= $past(onT))
      else $error("Alarm asserted before its on-delay.");
    AST_ON_ABORT: assert property (state_r == ST_ON_WAIT && !alarmCond[g] |=>
                                   state_r == ST_IDLE && cnt_r == 20'h0)
      else $error("On-delay not cleared on lost condition.");
    AST_OFF_HOLD: assert property (state_r == ST_ON && !alarmCond[g] && offT != 20'h0
                                   |=> dlyOn[g])
      else $error("Alarm dropped without off-delay.");
    AST_OFF_RESUME: assert property (state_r == ST_OFF_WAIT && alarmCond[g] |=>
                                     state_r == ST_ON && cnt_r == 20'h0)
      else $error("Off-delay not cleared on returning condition.");
  end

  // Latches: a new alarm wins over a release in the same cycle.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      latched_r      <= 3'h0;
      alarmOut_r     <= 3'h0;
      latchRelease_r <= 1'b0;
    end
    else
    begin
      latchRelease_r <= contactRise_r && (contactFunc_r == FN_LATCH);
      latched_r  <= (dlyOn & latchEn_r) | (latched_r & {3{!latchRelease_r}});
      alarmOut_r <= dlyOn | (latched_r & latchEn_r);
    end

  AST_LATCH_ALL: assert property (latchRelease_r && dlyOn == 3'h0 |=> latched_r == 3'h0)
    else $error("Latch release left a latched alarm.");

  // Backlight and message interruption.
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      backlightOn_r   <= RST_BACKLIGHT;
      messageActive_r <= 1'b0;
      messageSel_r    <= 2'h0;
    end
    else
    begin
      if (contactFunc_r == FN_BACKLIGHT)
      begin
        if (contactRise_r)
          backlightOn_r <= 1'b0;
        else if (contactFall_r)
          backlightOn_r <= 1'b1;
      end
      if (contactRise_r && contactFunc_r >= FN_MSG1)
      begin
        messageActive_r <= 1'b1;
        messageSel_r    <= 2'(contactFunc_r - FN_MSG1);
      end
      else if (keyPress_r || (contactFall_r && contactFunc_r >= FN_MSG1))
        messageActive_r <= 1'b0;
    end

  AST_BACKLIGHT_OFF: assert property (contactRise_r && contactFunc_r == FN_BACKLIGHT
                                      |=> !backlightOn_r)
    else $error("Backlight not switched off on rise.");
  AST_MSG_SHOW: assert property (sRiseSeen and contactFunc_r >= FN_MSG1 |=> sMsgShown)
    else $error("Message not shown on rise.");
  AST_MSG_CLEAR: assert property (keyPress_r && !contactRise_r |=> !messageActive_r)
    else $error("Display key did not remove message.");

  // Colour selection.
  assign dev    = 17'(pv_r) - 17'(sp_r);
  assign devOut = (dev > 17'(colHigh_r)) || (dev < 17'(colLow_r));
  assign pvOut  = (pv_r > colHigh_r) || (pv_r < colLow_r);

  always_comb
    case (colourMode_r)
      CM_WHITE:    redNxt = 1'b0;
      CM_RED:      redNxt = 1'b1;
      CM_AL1:      redNxt = alarmOut_r[0];
      CM_AL1_INV:  redNxt = !alarmOut_r[0];
      CM_AL12:     redNxt = alarmOut_r[0] || alarmOut_r[1];
      CM_AL12_INV: redNxt = !(alarmOut_r[0] || alarmOut_r[1]);
      CM_PV:       redNxt = pvOut;
      CM_PV_INV:   redNxt = !pvOut;
      CM_DEV:      redNxt = devOut;
      CM_DEV_INV:  redNxt = !devOut;
      CM_CONTACT:  redNxt = contactLvl_r && (contactFunc_r == FN_COLOUR);
      CM_EXCEED:   redNxt = exceededLamp;
      CM_OUTLAMP:  redNxt = outLamp;
      default:     redNxt = 1'b0;
    endcase

  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      displayRed_r <= 1'b0;
    else
      displayRed_r <= redNxt;

  AST_COLOUR_SWITCH: assert property (colourMode_r == CM_CONTACT && contactFunc_r == FN_COLOUR
                                      |=> displayRed_r == $past(contactLvl_r))
    else $error("Colour does not follow contact.");
  AST_FIXED_RED: assert property (colourMode_r == CM_RED |=> displayRed_r)
    else $error("Fixed red not shown.");
  AST_DEVIATION: assert property (colourMode_r == CM_DEV && devOut |=> displayRed_r)
    else $error("Deviation outside band not red.");

  assign alarmOut      = alarmOut_r;
  assign latchRelease  = latchRelease_r;
  assign backlightOn   = backlightOn_r;
  assign displayRed    = displayRed_r;
  assign messageActive = messageActive_r;
  assign messageSel    = messageSel_r;
endmodule
`default_nettype wire

// [test/contact_partner.sv]
// Model of the dry contact and the alarm condition evaluator.
`timescale 1ns/1ps
`default_nettype none
module contact_partner (
  input  wire logic       clk,
  output logic            contactPin,
  output logic [2:0]      alarmCond
);
  localparam int HOLD_CYCLES = 140;
  initial
  begin
    contactPin = 1'b0;
    alarmCond = 3'h0;
  end
  // Each new contact level is held well past the qualification time.
  task automatic setContact(input logic lvl);
    @(posedge clk);
    contactPin <= lvl;
    repeat (HOLD_CYCLES) @(negedge clk);
  endtask
  task automatic setCond(input logic [2:0] c);
    @(posedge clk);
    alarmCond <= c;
  endtask
endmodule
`default_nettype wire

// [test/test_alarm_delay_contact_input_color_logic.sv]
// Testbench for the alarm delay, contact input and colour logic.
`timescale 1ns/1ps
`default_nettype none
module test_alarm_delay_contact_input_color_logic;
  import alarm_event_pkg::*;
  logic clk = 1'b0;
  logic nrst, awv, wv, br, arv, rr, lampEx, lampOut;
  logic [7:0] awa, ara;
  logic [3:0] strb;
  logic [31:0] wd, rdata, rdVal;
  logic [1:0] bresp, rresp, resp, sel;
  logic awr, wr, bv, arr, rv, pin, rel, bl, red, msg;
  logic [2:0] cond, alarm;
  int numErrors = 0, checkCount = 0, relCount = 0, onCount = 0, offCount = 0;
  contact_partner partner (.clk(clk), .contactPin(pin), .alarmCond(cond));
  alarm_event_logic #(.TICK_CYCLES(4)) DUT (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .contactPin(pin), .alarmCond(cond), .exceededLamp(lampEx), .outLamp(lampOut),
    .alarmOut(alarm), .latchRelease(rel), .backlightOn(bl), .displayRed(red),
    .messageActive(msg), .messageSel(sel));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    if (rel === 1'b1) relCount <= relCount + 1;
    if (alarm[0] === 1'b1) onCount <= onCount + 1;
    if (alarm[0] === 1'b0) offCount <= offCount + 1;
  end
  task automatic printVerdict();
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    numErrors++;
    $display("wrong value at %0t: no answer", $time);
    printVerdict();
  endtask
  task automatic axiW(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aDone, wDone, bDone;
    aDone = 1'b0; wDone = 1'b0; bDone = 1'b0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    for (n = 0; n < 50 && !(aDone && wDone); n++)
    begin
      @(negedge clk);
      if (awv && awr === 1'b1) aDone = 1'b1;
      if (wv && wr === 1'b1) wDone = 1'b1;
      @(posedge clk);
      if (aDone) awv <= 1'b0;
      if (wDone) wv <= 1'b0;
    end
    br <= 1'b1;
    for (n = 0; n < 50 && !bDone; n++)
    begin
      @(negedge clk);
      if (bv === 1'b1) begin resp = bresp; bDone = 1'b1; end
      @(posedge clk);
    end
    br <= 1'b0;
    if (!(aDone && wDone && bDone)) hang();
  endtask
  task automatic axiR(input logic [7:0] a);
    int n;
    logic aDone, rDone;
    aDone = 1'b0; rDone = 1'b0;
    @(posedge clk);
    ara <= a; arv <= 1'b1;
    for (n = 0; n < 50 && !aDone; n++)
    begin
      @(negedge clk);
      if (arr === 1'b1) aDone = 1'b1;
      @(posedge clk);
    end
    arv <= 1'b0; rr <= 1'b1;
    for (n = 0; n < 50 && !rDone; n++)
    begin
      @(negedge clk);
      if (rv === 1'b1) begin rdVal = rdata; resp = rresp; rDone = 1'b1; end
      @(posedge clk);
    end
    rr <= 1'b0;
    if (!(aDone && rDone)) hang();
  endtask
  task automatic waitAlarm(input logic v);
    int n;
    for (n = 0; n < 40 && alarm[0] !== v; n++) @(negedge clk);
    if (alarm[0] !== v) hang();
  endtask
  task automatic testRegs();
    axiR(OFS_STATUS);
    check(rdVal, 32'h00000010);
    axiR(8'h2C);
    check(rdVal, 32'h0);
    check(32'(resp), 32'h2);
    axiW(8'h2C, 32'h1);
    check(32'(resp), 32'h2);
    axiW(OFS_ON_DLY + 8'h04, 32'h00007F3F);
    check(32'(resp), 32'h0);
    axiR(OFS_ON_DLY + 8'h04);
    check(rdVal, 32'h0000633B);
    strb <= 4'h2;
    axiW(OFS_ON_DLY + 8'h04, 32'h0);
    strb <= 4'hF;
    axiR(OFS_ON_DLY + 8'h04);
    check(rdVal, 32'h0000003B);
    axiW(OFS_ON_DLY + 8'h04, 32'h0);
  endtask
  task automatic testDelays();
    int n0;
    axiW(OFS_ON_DLY, 32'h00000001);
    axiW(OFS_OFF_DLY, 32'h00000001);
    n0 = onCount;
    partner.setCond(3'h1);
    repeat (300) @(posedge clk);
    partner.setCond(3'h0);
    repeat (600) @(negedge clk);
    check(onCount - n0, 32'h0);
    partner.setCond(3'h1);
    repeat (390) @(negedge clk);
    check(32'(alarm[0]), 32'h0);
    waitAlarm(1'b1);
    n0 = offCount;
    partner.setCond(3'h0);
    repeat (200) @(posedge clk);
    partner.setCond(3'h1);
    repeat (300) @(negedge clk);
    check(offCount - n0, 32'h0);
    partner.setCond(3'h0);
    repeat (390) @(negedge clk);
    check(32'(alarm[0]), 32'h1);
    waitAlarm(1'b0);
    axiW(OFS_ON_DLY, 32'h0);
    axiW(OFS_OFF_DLY, 32'h0);
  endtask
  task automatic testLatch();
    axiW(OFS_LATCH, 32'h7);
    axiW(OFS_CONTACT, 32'(FN_LATCH));
    partner.setCond(3'h6);
    repeat (5) @(posedge clk);
    partner.setCond(3'h0);
    repeat (5) @(negedge clk);
    check(32'(alarm), 32'h6);
    partner.setContact(1'b1);
    check(relCount, 32'd1);
    check(32'(alarm), 32'h0);
    check(32'(bl), 32'h1);
    partner.setContact(1'b0);
    check(relCount, 32'd1);
    axiW(OFS_LATCH, 32'h0);
  endtask
  task automatic testContact();
    axiW(OFS_CONTACT, 32'(FN_BACKLIGHT));
    partner.setContact(1'b1);
    check({30'h0, bl, msg}, 32'h0);
    partner.setContact(1'b0);
    check(32'(bl), 32'h1);
    axiW(OFS_CONTACT, 32'h5);
    partner.setContact(1'b1);
    check({29'h0, msg, sel}, 32'h5);
    axiW(OFS_KEY, 32'h1);
    @(negedge clk);
    check(32'(msg), 32'h0);
    partner.setContact(1'b0);
    partner.setContact(1'b1);
    check(32'(msg), 32'h1);
    partner.setContact(1'b0);
    check(32'(msg), 32'h0);
    axiW(OFS_CONTACT, 32'(FN_COLOUR));
    axiW(OFS_COLOUR, 32'(CM_CONTACT));
    partner.setContact(1'b1);
    check(32'(red), 32'h1);
    axiR(OFS_STATUS);
    check(rdVal, 32'h00001130);
    partner.setContact(1'b0);
    check(32'(red), 32'h0);
  endtask
  task automatic colourPass(input logic [12:0] exp);
    logic [3:0] modes [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                               4'hB, 4'hC, 4'hD};
    for (int i = 0; i < 13; i++)
    begin
      axiW(OFS_COLOUR, 32'(modes[i]));
      repeat (4) @(negedge clk);
      check(32'(red), 32'(exp[i]));
    end
  endtask
  task automatic testColour();
    axiW(OFS_COL_HIGH, 32'd70);
    axiW(OFS_COL_LOW, 32'd20);
    axiW(OFS_PV, 32'd80);
    axiW(OFS_SP, 32'd20);
    colourPass(13'h066A);
    lampEx <= 1'b0;
    lampOut <= 1'b1;
    axiW(OFS_PV, 32'd15);
    axiW(OFS_SP, 32'd40);
    partner.setCond(3'h1);
    colourPass(13'h0956);
    partner.setCond(3'h0);
  endtask
  initial
  begin
    nrst <= 1'b0;
    awv <= 1'b0;
    wv <= 1'b0;
    br <= 1'b0;
    arv <= 1'b0;
    rr <= 1'b0;
    awa <= 8'h00;
    ara <= 8'h00;
    wd <= 32'h0;
    strb <= 4'hF;
    lampEx <= 1'b1;
    lampOut <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    testRegs();
    testDelays();
    testLatch();
    testContact();
    testColour();
    printVerdict();
  end
endmodule
`default_nettype wire
